// *** core/tps_supervisor.sv ***
// touch panel supervisor: debounce, clamp, exclusive buttons, log, errors, watchdog
`timescale 1ns/1ps
`default_nettype none
`include "tps_defines.svh"

module tps_supervisor #(
   parameter int LOG_DEPTH     = 16,
   parameter int WDT_CYCLES    = `TPS_WDT_CYCLES,
   parameter int POST_CYCLES   = `TPS_POST_CYCLES,
   parameter int TICKS_PER_SEC = `TPS_CLK_HZ
) (
   input  wire logic                CLK,
   input  wire logic                RESET,
   input  wire logic                WB_CYC_I,
   input  wire logic                WB_STB_I,
   input  wire logic                WB_WE_I,
   input  wire logic [7:0]          WB_ADR_I,
   input  wire logic [3:0]          WB_SEL_I,
   input  wire logic [31:0]         WB_DAT_I,
   output var  logic [31:0]         WB_DAT_O,
   output var  logic                WB_ACK_O,
   input  wire logic                SMP_VALID,
   input  wire tps_pkg::tps_sample_t SMP,
   input  wire logic [9:0]          SLIDER_RAW,
   input  wire logic                ERR_VALID,
   input  wire tps_pkg::tps_err_t   ERR,
   input  wire logic                VACANT_ACCESS,
   input  wire logic [7:0]          RESET_CAUSE_VECTOR,
   input  wire logic                NV_INIT,
   output var  logic [31:0]         LED_STATE,
   output var  logic [7:0]          SLIDER_POS,
   output var  logic                LED_LATCH,
   output var  logic                LED_NOISE,
   output var  logic                LED_FAULT,
   output var  logic                HALTED,
   output var  logic                WDT_RESET_REQ
);

   localparam int LW = $clog2(LOG_DEPTH);

   // ==========================================================
   // helpers
   function automatic logic [2:0] deb_step(input logic st, input logic raw,
                                            input logic [1:0] cnt);
      if (raw == st)
         return {st, 2'd0};
      else if (cnt == `TPS_DEB_SAMPLES)
         return {raw, 2'd0};
      else
         return {st, 2'(cnt + 2'd1)};
   endfunction

   function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   function automatic logic [4:0] lowest_idx(input logic [31:0] v);
      logic [4:0] r;
      r = 5'd0;
      for (int i = 31; i >= 0; i--)
         if (v[i])
            r = 5'(i);
      return r;
   endfunction

   // ==========================================================
   // state
   tps_pkg::tps_state_t state_reg, state_next;
   logic [31:0]      post_cnt_reg;
   logic             nv_s1_reg, nv_s2_reg;
   logic             ctrl_mutual_reg;
   logic [31:0]      deb_touch_reg, deb_prox_reg, noise_reg;
   logic [1:0]       tcnt_reg [32];
   logic [1:0]       pcnt_reg [32];
   logic [1:0]       own_v_reg;
   logic [4:0]       own0_reg, own1_reg;
   logic [7:0]       slider_reg;
   logic [9:0]       count_reg;
   logic             latch_reg;
   logic [7:0]       last_err_reg;
   logic             boot_pend_reg;
   tps_pkg::tps_log_t log_mem [LOG_DEPTH];
   logic [LW-1:0]    wptr_reg, log_sel_reg;
   logic             wrapped_reg;
   logic [31:0]      presc_reg, sec_rst_reg, sec_birth_reg, wdt_cnt_reg;
   logic             wdt_rst_reg;
   logic             ack_reg, wait_reg;
   logic [31:0]      dat_reg;
   logic [31:0]      led_reg;
   logic             noise_led_reg;

   // ==========================================================
   // sampling path
   wire       running    = (state_reg == tps_pkg::TPS_ST_RUN);
   wire       take       = SMP_VALID && !(state_reg == tps_pkg::TPS_ST_HALT);
   wire [9:0] lim        = ctrl_mutual_reg ? `TPS_MUT_MAX_COUNT : `TPS_SELF_MAX_COUNT;
   wire [9:0] clamped    = clamp(SMP.count, lim);
   wire [2:0] t_step     = deb_step(deb_touch_reg[SMP.elem], SMP.touch,
                                    tcnt_reg[SMP.elem]);
   wire [2:0] p_step     = deb_step(deb_prox_reg[SMP.elem], SMP.prox,
                                    pcnt_reg[SMP.elem]);
   wire       t_flip     = take && (t_step[2] != deb_touch_reg[SMP.elem]);

   // ==========================================================
   // exclusive button groups
   wire [31:0] g0_mask   = ctrl_mutual_reg ? `TPS_MAT0_MASK : `TPS_SELF_BTN_MASK;
   wire [31:0] g1_mask   = ctrl_mutual_reg ? `TPS_MAT1_MASK : 32'h0000_0000;
   wire [31:0] free_mask = ctrl_mutual_reg ? 32'h0000_0000 : `TPS_SELF_SLD_MASK;
   wire [31:0] g0_touch  = deb_touch_reg & g0_mask;
   wire [31:0] g1_touch  = deb_touch_reg & g1_mask;
   wire [31:0] own0_hot  = own_v_reg[0] ? (32'h0000_0001 << own0_reg) : 32'h0000_0000;
   wire [31:0] own1_hot  = own_v_reg[1] ? (32'h0000_0001 << own1_reg) : 32'h0000_0000;
   // in self mode slider elements bypass the ownership gate; in mutual mode they fall in group 0
   wire [31:0] shown     = (deb_touch_reg & free_mask) | (g0_touch & own0_hot)
                         | (g1_touch & own1_hot);
   wire        sld_touch = |(deb_touch_reg & free_mask);

   // ==========================================================
   // log source selection, boot first, then errors, then touch
   wire        err_any   = ERR_VALID || VACANT_ACCESS;
   wire        err_fatal = VACANT_ACCESS || (ERR_VALID && ERR.fatal);
   wire [7:0]  err_code  = VACANT_ACCESS ? `TPS_ERR_VACANT : ERR.code;
   // nothing is logged while reset is held, so each boot leaves one entry
   wire        log_we    = !RESET && (boot_pend_reg || err_any || (t_flip && running));
   wire [3:0]  log_sys   = boot_pend_reg ? `TPS_SYS_BOOT
                         : err_any ? `TPS_SYS_ERR : `TPS_SYS_TOUCH;
   wire [7:0]  log_msg   = boot_pend_reg ? `TPS_MSG_RESET_CAUSE
                         : err_any ? (err_fatal ? `TPS_MSG_FATAL : `TPS_MSG_NONFATAL)
                         : (t_step[2] ? `TPS_MSG_TOUCH : `TPS_MSG_RELEASE);
   wire [15:0] log_pay   = boot_pend_reg ? {8'h00, RESET_CAUSE_VECTOR}
                         : err_any ? {8'h00, err_code} : {11'h000, SMP.elem};
   wire tps_pkg::tps_log_t log_entry = '{ts: sec_rst_reg, subsystem_id: log_sys,
                                         message_id: log_msg,
                                         message_payload: log_pay};

   // ==========================================================
   // bus decode
   wire        req       = WB_CYC_I && WB_STB_I && !ack_reg;
   wire        nv_area   = (WB_ADR_I == `TPS_ADR_LOGTS) || (WB_ADR_I == `TPS_ADR_LOGINFO);
   // retained memory answers one cycle later than plain registers
   wire        ack_next  = req && (!nv_area || wait_reg);
   wire        wr        = ack_next && WB_WE_I && WB_SEL_I[0];
   wire        wdt_kick  = wr && (WB_ADR_I == `TPS_ADR_WDT) && (WB_DAT_I[7:0] == `TPS_WDT_KEY);
   wire tps_pkg::tps_log_t sel_entry = log_mem[log_sel_reg];
   wire [31:0] rd_data =
      (WB_ADR_I == `TPS_ADR_CTRL)     ? {31'h0, ctrl_mutual_reg} :
      (WB_ADR_I == `TPS_ADR_STATUS)   ? {16'h0, slider_reg, 4'h0, noise_led_reg, latch_reg,
                                         (state_reg == tps_pkg::TPS_ST_POST),
                                         (state_reg == tps_pkg::TPS_ST_HALT)} :
      (WB_ADR_I == `TPS_ADR_LOGPTR)   ? {23'h0, wrapped_reg, 8'(wptr_reg)} :
      (WB_ADR_I == `TPS_ADR_LOGSEL)   ? 32'(log_sel_reg) :
      (WB_ADR_I == `TPS_ADR_LOGTS)    ? sel_entry.ts :
      (WB_ADR_I == `TPS_ADR_LOGINFO)  ? {4'h0, sel_entry.subsystem_id, sel_entry.message_id,
                                         sel_entry.message_payload} :
      (WB_ADR_I == `TPS_ADR_SECRST)   ? sec_rst_reg :
      (WB_ADR_I == `TPS_ADR_SECBIRTH) ? sec_birth_reg :
      (WB_ADR_I == `TPS_ADR_TOUCH)    ? deb_touch_reg :
      (WB_ADR_I == `TPS_ADR_LASTERR)  ? {24'h0, last_err_reg} :
      (WB_ADR_I == `TPS_ADR_COUNT)    ? {22'h0, count_reg} : 32'h0000_0000;

   // ==========================================================
   // mode sequencing
   always_comb begin
      case (state_reg)
         tps_pkg::TPS_ST_POST: state_next = (post_cnt_reg >= 32'(POST_CYCLES - 1))
                                            ? tps_pkg::TPS_ST_RUN : tps_pkg::TPS_ST_POST;
         tps_pkg::TPS_ST_RUN:  state_next = tps_pkg::TPS_ST_RUN;
         tps_pkg::TPS_ST_HALT: state_next = tps_pkg::TPS_ST_HALT;
         default:              state_next = tps_pkg::TPS_ST_HALT;
      endcase
      if (err_fatal)
         state_next = tps_pkg::TPS_ST_HALT;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_reg    <= tps_pkg::TPS_ST_POST;
         post_cnt_reg <= 32'h0000_0000;
      end else begin
         state_reg    <= state_next;
         post_cnt_reg <= post_cnt_reg + 32'h0000_0001;
      end
   end

   // ==========================================================
   // retained state: cleared only by programming, never by reset
   always_ff @(posedge CLK) begin
      nv_s1_reg <= NV_INIT;
      nv_s2_reg <= nv_s1_reg;
   end

   always_ff @(posedge CLK) begin
      if (nv_s2_reg) begin
         deb_touch_reg <= 32'h0000_0000;
         slider_reg    <= 8'h00;
         sec_birth_reg <= 32'h0000_0000;
         wptr_reg      <= '0;
         wrapped_reg   <= 1'b0;
      end else begin
         if (take)
            deb_touch_reg[SMP.elem] <= t_step[2];
         if (sld_touch && running)
            slider_reg <= SLIDER_RAW[9:2];
         if (!RESET && presc_reg == 32'(TICKS_PER_SEC - 1))
            sec_birth_reg <= sec_birth_reg + 32'h0000_0001;
         if (log_we) begin
            wptr_reg <= wptr_reg + LW'(1);
            if (wptr_reg == LW'(LOG_DEPTH - 1))
               wrapped_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (log_we)
         log_mem[wptr_reg] <= log_entry;
   end

   // ==========================================================
   // volatile sensing state
   always_ff @(posedge CLK) begin
      if (RESET) begin
         deb_prox_reg <= 32'h0000_0000;
         noise_reg    <= 32'h0000_0000;
         count_reg    <= 10'h000;
         own_v_reg    <= 2'b00;
         own0_reg     <= 5'h00;
         own1_reg     <= 5'h00;
         latch_reg    <= 1'b0;
         for (int i = 0; i < 32; i++) begin
            tcnt_reg[i] <= 2'd0;
            pcnt_reg[i] <= 2'd0;
         end
      end else begin
         if (take) begin
            tcnt_reg[SMP.elem]     <= t_step[1:0];
            pcnt_reg[SMP.elem]     <= p_step[1:0];
            deb_prox_reg[SMP.elem] <= p_step[2];
            noise_reg[SMP.elem]    <= SMP.noise;
            count_reg              <= clamped;
         end
         // owner kept until the whole group reads released
         if (g0_touch == 32'h0000_0000)
            own_v_reg[0] <= 1'b0;
         else if (!own_v_reg[0]) begin
            own_v_reg[0] <= 1'b1;
            own0_reg     <= lowest_idx(g0_touch);
         end
         if (g1_touch == 32'h0000_0000)
            own_v_reg[1] <= 1'b0;
         else if (!own_v_reg[1]) begin
            own_v_reg[1] <= 1'b1;
            own1_reg     <= lowest_idx(g1_touch);
         end
         if (running && (deb_touch_reg != 32'h0000_0000))
            latch_reg <= 1'b1;
      end
   end

   // ==========================================================
   // errors, boot cause, timestamps, watchdog
   always_ff @(posedge CLK) begin
      if (RESET) begin
         last_err_reg  <= 8'h00;
         boot_pend_reg <= 1'b1;
         presc_reg     <= 32'h0000_0000;
         sec_rst_reg   <= 32'h0000_0000;
         wdt_cnt_reg   <= 32'h0000_0000;
         wdt_rst_reg   <= 1'b0;
      end else begin
         boot_pend_reg <= 1'b0;
         if (err_any && !boot_pend_reg)
            last_err_reg <= err_code;
         if (presc_reg == 32'(TICKS_PER_SEC - 1)) begin
            presc_reg   <= 32'h0000_0000;
            sec_rst_reg <= sec_rst_reg + 32'h0000_0001;
         end else
            presc_reg <= presc_reg + 32'h0000_0001;
         if (wdt_kick || wdt_cnt_reg == 32'(WDT_CYCLES - 1))
            wdt_cnt_reg <= 32'h0000_0000;
         else
            wdt_cnt_reg <= wdt_cnt_reg + 32'h0000_0001;
         wdt_rst_reg <= !wdt_kick && (wdt_cnt_reg == 32'(WDT_CYCLES - 1));
      end
   end

   // ==========================================================
   // wishbone slave
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ack_reg         <= 1'b0;
         wait_reg        <= 1'b0;
         dat_reg         <= 32'h0000_0000;
         ctrl_mutual_reg <= `TPS_CTRL_RESET;
         log_sel_reg     <= '0;
      end else begin
         ack_reg  <= ack_next;
         wait_reg <= req && nv_area && !wait_reg;
         if (ack_next)
            dat_reg <= rd_data;
         if (wr && WB_ADR_I == `TPS_ADR_CTRL)
            ctrl_mutual_reg <= WB_DAT_I[`TPS_CTRL_MUTUAL_BIT];
         if (wr && WB_ADR_I == `TPS_ADR_LOGSEL)
            log_sel_reg <= WB_DAT_I[LW-1:0];
      end
   end

   // ==========================================================
   // indicator outputs
   always_ff @(posedge CLK) begin
      if (RESET) begin
         led_reg       <= 32'hffff_ffff;
         noise_led_reg <= 1'b0;
      end else begin
         // test pattern first, retained states only afterwards
         led_reg       <= (state_next == tps_pkg::TPS_ST_POST) ? 32'hffff_ffff : shown;
         noise_led_reg <= |noise_reg;
      end
   end

   wire post_on = (state_reg == tps_pkg::TPS_ST_POST);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         LED_LATCH     <= 1'b1;
         LED_NOISE     <= 1'b1;
         LED_FAULT     <= 1'b1;
         HALTED        <= 1'b0;
         SLIDER_POS    <= 8'h00;
         WDT_RESET_REQ <= 1'b0;
      end else begin
         LED_LATCH     <= post_on || latch_reg;
         LED_NOISE     <= post_on || noise_led_reg;
         LED_FAULT     <= post_on || (state_reg == tps_pkg::TPS_ST_HALT);
         HALTED        <= (state_reg == tps_pkg::TPS_ST_HALT);
         SLIDER_POS    <= slider_reg;
         WDT_RESET_REQ <= wdt_rst_reg;
      end
   end

   assign LED_STATE = led_reg;
   assign WB_DAT_O  = dat_reg;
   assign WB_ACK_O  = ack_reg;

endmodule

`default_nettype wire

// *** shared/tps_defines.svh ***
// constants of the touch panel supervisor: offsets, reset values, limits, timing
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

// ==========================================================
// register byte offsets
`define TPS_ADR_CTRL      8'h00
`define TPS_ADR_STATUS    8'h04
`define TPS_ADR_WDT       8'h08
`define TPS_ADR_LOGPTR    8'h0c
`define TPS_ADR_LOGSEL    8'h10
`define TPS_ADR_LOGTS     8'h14
`define TPS_ADR_LOGINFO   8'h18
`define TPS_ADR_SECRST    8'h1c
`define TPS_ADR_SECBIRTH  8'h20
`define TPS_ADR_TOUCH     8'h24
`define TPS_ADR_LASTERR   8'h28
`define TPS_ADR_COUNT     8'h2c

// ==========================================================
// fields and reset values
`define TPS_CTRL_MUTUAL_BIT 0
`define TPS_CTRL_RESET      1'b0
`define TPS_WDT_KEY         8'h5a

// ==========================================================
// sensing limits
`define TPS_DEB_SAMPLES     2'd2
`define TPS_SELF_MAX_COUNT  10'd625
// 600 leaves 200 counts of headroom over the 400 mutual baseline
`define TPS_MUT_MAX_COUNT   10'd600
`define TPS_SELF_BTN_MASK   32'h0000_0fff
`define TPS_SELF_SLD_MASK   32'h0000_f000
`define TPS_MAT0_MASK       32'h0000_ffff
`define TPS_MAT1_MASK       32'hffff_0000

// ==========================================================
// timing
`define TPS_CLK_HZ          10000000
`define TPS_WDT_TIMEOUT_S   16
`define TPS_WDT_CYCLES      (`TPS_WDT_TIMEOUT_S * `TPS_CLK_HZ)
`define TPS_POST_MS         500
`define TPS_POST_CYCLES     (`TPS_POST_MS * (`TPS_CLK_HZ / 1000))

// ==========================================================
// log identifiers
`define TPS_SYS_BOOT        4'h1
`define TPS_SYS_ERR         4'h2
`define TPS_SYS_TOUCH       4'h3
`define TPS_MSG_RESET_CAUSE 8'h01
`define TPS_MSG_FATAL       8'h02
`define TPS_MSG_NONFATAL    8'h03
`define TPS_MSG_TOUCH       8'h04
`define TPS_MSG_RELEASE     8'h05
`define TPS_ERR_VACANT      8'hff

`endif

// *** shared/tps_pkg.sv ***
// types shared by the touch panel supervisor and its bench
package tps_pkg;

   typedef struct packed {
      logic       touch;
      logic       prox;
      logic       noise;
      logic [4:0] elem;
      logic [9:0] count;
   } tps_sample_t;

   typedef struct packed {
      logic       fatal;
      logic [7:0] code;
   } tps_err_t;

   typedef struct packed {
      logic [31:0] ts;
      logic [3:0]  subsystem_id;
      logic [7:0]  message_id;
      logic [15:0] message_payload;
   } tps_log_t;

   typedef enum logic [2:0] {
      TPS_ST_POST = 3'b001,
      TPS_ST_RUN  = 3'b010,
      TPS_ST_HALT = 3'b100
   } tps_state_t;

endpackage

// *** tb/tb.sv ***
// self-checking bench for the touch panel supervisor
`timescale 1ns/1ps
`default_nettype none
`include "tps_defines.svh"
module tb;
   localparam int POST = 8;
   localparam int WDT  = 300;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} tps_exp_t;
   logic                 CLK;
   logic                 RESET;
   logic                 WB_CYC_I;
   logic                 WB_STB_I;
   logic                 WB_WE_I;
   logic [7:0]           WB_ADR_I;
   logic [3:0]           WB_SEL_I;
   logic [31:0]          WB_DAT_I;
   logic [31:0]          WB_DAT_O;
   logic                 WB_ACK_O;
   logic                 SMP_VALID;
   tps_pkg::tps_sample_t SMP;
   logic [9:0]           SLIDER_RAW;
   logic                 ERR_VALID;
   tps_pkg::tps_err_t    ERR;
   logic                 VACANT_ACCESS;
   logic [7:0]           RESET_CAUSE_VECTOR;
   logic                 NV_INIT;
   logic [31:0]          LED_STATE;
   logic [7:0]           SLIDER_POS;
   logic                 LED_LATCH;
   logic                 LED_NOISE;
   logic                 LED_FAULT;
   logic                 HALTED;
   logic                 WDT_RESET_REQ;
   int                   num_errors = 0;
   int                   n_compared = 0;
   int                   n;
   tps_exp_t             exp_q[$];
   tps_exp_t             x;
   logic [7:0]           cause;
   logic [7:0]           code[5];
   logic [9:0]           sld;
   tps_supervisor #(.LOG_DEPTH(4), .WDT_CYCLES(WDT), .POST_CYCLES(POST),
      .TICKS_PER_SEC(10)) dut_u (.*);
   tps_front_model fe_u (.clk(CLK), .smp_valid(SMP_VALID), .smp(SMP), .slider_raw(SLIDER_RAW));
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   // ==========================================================
   // checking and driving tasks
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(logic we, logic [7:0] a, logic [31:0] d, logic [31:0] m, string nm);
      int k;
      if (!we) exp_q.push_back('{nm, d, m});
      @(posedge CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      for (k = 1; k <= 20; k++) begin
         @(posedge CLK);
         if (WB_ACK_O === 1'b1) break;
      end
      if (k > 20) begin
         chk("bus answer", 0, 1);
         stop_test();
      end
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask
   task automatic err(logic f, logic [7:0] c, logic vac);
      @(posedge CLK);
      ERR_VALID <= !vac;
      VACANT_ACCESS <= vac;
      ERR <= '{f, c};
      @(posedge CLK);
      ERR_VALID <= 1'b0;
      VACANT_ACCESS <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   task automatic rst();
      cause = 8'($urandom);
      @(posedge CLK);
      RESET <= 1'b1;
      RESET_CAUSE_VECTOR <= cause;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      wb(0, `TPS_ADR_SECRST, 0, '1, "reset seconds");
      repeat (POST + 4) @(posedge CLK);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // read results checked in issue order
   always @(posedge CLK) begin
      if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0) begin
         if (exp_q.size() == 0) chk("spare ack", 0, 1);
         else begin
            x = exp_q.pop_front();
            chk(x.nm, x.e & x.m, WB_DAT_O & x.m);
         end
      end
   end
   initial begin
      repeat (100000) @(posedge CLK);
      chk("run length", 0, 1);
      stop_test();
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(73916));
      RESET = 1'b1;
      NV_INIT = 1'b1;
      {WB_CYC_I, WB_STB_I, WB_WE_I, ERR_VALID, VACANT_ACCESS} = 5'h00;
      WB_ADR_I = 8'h00;
      WB_SEL_I = 4'hf;
      WB_DAT_I = 32'h0;
      ERR = '0;
      RESET_CAUSE_VECTOR = 8'h00;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      repeat (4) @(posedge CLK);
      NV_INIT <= 1'b0;
      repeat (4) @(posedge CLK);
      rst();
      wb(1, `TPS_ADR_LOGSEL, 0, 0, "");
      wb(0, `TPS_ADR_LOGINFO, {4'h0, `TPS_SYS_BOOT, `TPS_MSG_RESET_CAUSE, 8'h00, cause},
         32'h0fff_00ff, "boot entry");
      // five soft errors overrun the four-deep log
      for (int i = 0; i < 5; i++) begin
         code[i] = 8'($urandom);
         err(1'b0, code[i], 1'b0);
      end
      wb(0, `TPS_ADR_LOGPTR, 32'h102, 32'h1ff, "log pointer");
      for (int i = 0; i < 2; i++) begin
         wb(1, `TPS_ADR_LOGSEL, i, 0, "");
         wb(0, `TPS_ADR_LOGINFO, {4'h0, `TPS_SYS_ERR, `TPS_MSG_NONFATAL, 8'h00, code[i+3]},
            32'h0fff_00ff, "soft entry");
      end
      wb(0, `TPS_ADR_LASTERR, code[4], 32'hff, "last error");
      chk("soft halt", 0, HALTED);
      $display("test log done");
      fe_u.send(5'd3, 1'b1, 1'b0, 10'd0, 2);
      wb(0, `TPS_ADR_TOUCH, 0, '1, "two samples");
      fe_u.send(5'd3, 1'b1, 1'b0, 10'd0, 1);
      wb(0, `TPS_ADR_TOUCH, 32'h8, '1, "three samples");
      fe_u.send(5'd5, 1'b1, 1'b0, 10'd0, 3);
      sld = 10'($urandom);
      fe_u.slide(sld);
      fe_u.send(5'd12, 1'b1, 1'b0, 10'd0, 3);
      wb(0, `TPS_ADR_TOUCH, 32'h1028, '1, "raw touch");
      repeat (4) @(posedge CLK);
      chk("owner leds", 32'h1008, LED_STATE);
      chk("slider", 32'(sld[9:2]), 32'(SLIDER_POS));
      chk("latch", 1, LED_LATCH);
      fe_u.send(5'd3, 1'b0, 1'b0, 10'd0, 3);
      repeat (4) @(posedge CLK);
      chk("others held", 32'h1000, LED_STATE);
      fe_u.send(5'd5, 1'b0, 1'b0, 10'd0, 3);
      fe_u.send(5'd5, 1'b1, 1'b0, 10'd0, 3);
      fe_u.send(5'd7, 1'b0, 1'b1, 10'd0, 1);
      repeat (4) @(posedge CLK);
      chk("new owner", 32'h1020, LED_STATE);
      chk("noise", 1, LED_NOISE);
      $display("test touch done");
      fe_u.send(5'd20, 1'b0, 1'b0, 10'd626 + 10'($urandom_range(397)), 1);
      wb(0, `TPS_ADR_COUNT, 625, 32'h3ff, "self clamp");
      wb(1, `TPS_ADR_CTRL, 1, 0, "");
      fe_u.send(5'd20, 1'b0, 1'b0, 10'd601 + 10'($urandom_range(422)), 1);
      wb(0, `TPS_ADR_COUNT, 600, 32'h3ff, "mutual clamp");
      n = $urandom_range(600);
      fe_u.send(5'd20, 1'b0, 1'b0, 10'(n), 1);
      wb(0, `TPS_ADR_COUNT, n, 32'h3ff, "mutual pass");
      wb(1, `TPS_ADR_CTRL, 0, 0, "");
      wb(1, `TPS_ADR_WDT, 32'(`TPS_WDT_KEY), 0, "");
      n = 0;
      while (WDT_RESET_REQ !== 1'b1 && n < WDT + 50) begin
         @(posedge CLK);
         n++;
      end
      chk("wdt period", 1, 32'(n >= WDT - 3 && n <= WDT + 3));
      if (n >= WDT + 50) stop_test();
      $display("test clamp and watchdog done");
      err(1'b1, 8'($urandom), 1'b0);
      chk("fault", 1, LED_FAULT);
      chk("halted", 1, HALTED);
      fe_u.send(5'd9, 1'b1, 1'b0, 10'd0, 3);
      wb(0, `TPS_ADR_TOUCH, 32'h1020, '1, "halted touch");
      rst();
      chk("halt cleared", 0, HALTED);
      chk("retained leds", 32'h1020, LED_STATE);
      chk("retained slider", 32'(sld[9:2]), 32'(SLIDER_POS));
      err(1'b0, 8'h00, 1'b1);
      chk("vacant halt", 1, HALTED);
      wb(0, `TPS_ADR_LASTERR, 32'(`TPS_ERR_VACANT), 32'hff, "vacant code");
      $display("test fatal done");
      @(posedge CLK);
      stop_test();
   end
endmodule
`default_nettype wire

// *** tb/tps_assertions.sv ***
// port checker for the touch panel supervisor
`timescale 1ns/1ps
`default_nettype none
`include "tps_defines.svh"
module tps_assertions #(
   parameter int POST_CYCLES = 8,
   parameter int WDT_CYCLES  = 50
) (
   input wire logic                 CLK,
   input wire logic                 RESET,
   input wire logic                 WB_CYC_I,
   input wire logic                 WB_STB_I,
   input wire logic                 WB_WE_I,
   input wire logic [7:0]           WB_ADR_I,
   input wire logic [31:0]          WB_DAT_I,
   input wire logic                 WB_ACK_O,
   input wire logic                 SMP_VALID,
   input wire tps_pkg::tps_sample_t SMP,
   input wire logic                 ERR_VALID,
   input wire tps_pkg::tps_err_t    ERR,
   input wire logic                 VACANT_ACCESS,
   input wire logic [31:0]          LED_STATE,
   input wire logic                 LED_LATCH,
   input wire logic                 LED_NOISE,
   input wire logic                 LED_FAULT,
   input wire logic                 HALTED,
   input wire logic                 WDT_RESET_REQ
);
   logic [15:0] up_reg;
   logic [15:0] wdt_reg;
   wire         run_ok = up_reg > 16'(POST_CYCLES + 3);
   wire         kick = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O
                     & (WB_ADR_I == `TPS_ADR_WDT) & (WB_DAT_I[7:0] == `TPS_WDT_KEY);
   always_ff @(posedge CLK) begin
      if (RESET) up_reg <= 16'h0000;
      else if (!run_ok) up_reg <= up_reg + 16'h0001;
   end
   // service write lands one edge before its ack is seen, hence the slack below
   always_ff @(posedge CLK) begin
      if (RESET | WDT_RESET_REQ | kick) wdt_reg <= 16'h0000;
      else wdt_reg <= wdt_reg + 16'h0001;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_fatal;
      VACANT_ACCESS || (ERR_VALID && ERR.fatal);
   endsequence
   sequence s_soft;
      ERR_VALID && !ERR.fatal && !VACANT_ACCESS && !HALTED
         && !$past(ERR_VALID) && !$past(VACANT_ACCESS);
   endsequence
   chk_fatal_halts: assert property (run_ok ##0 s_fatal |-> ##[1:3] HALTED)
      else $error("fatal error did not halt");
   chk_soft_runs: assert property (run_ok ##0 s_soft |=> ##1 !HALTED)
      else $error("nonfatal error halted");
   chk_halt_locks: assert property (HALTED |=> HALTED)
      else $error("halt released without reset");
   chk_fault_led: assert property (run_ok |-> LED_FAULT == HALTED)
      else $error("fault led differs from halt");
   chk_post_leds: assert property (up_reg < 16'(POST_CYCLES - 1) |-> LED_STATE == '1)
      else $error("led not lit during test");
   chk_latch_holds: assert property (run_ok && LED_LATCH |=> LED_LATCH)
      else $error("latched detect cleared");
   chk_noise_led: assert property (run_ok && SMP_VALID && SMP.noise && !HALTED
      |-> ##[1:3] LED_NOISE)
      else $error("noise flag not shown");
   chk_wdt_period: assert property (WDT_RESET_REQ
      |-> wdt_reg >= 16'(WDT_CYCLES - 3) && wdt_reg <= 16'(WDT_CYCLES + 3))
      else $error("watchdog period wrong");
   chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
endmodule
bind tps_supervisor tps_assertions #(
   .POST_CYCLES(POST_CYCLES),
   .WDT_CYCLES (WDT_CYCLES)
) chk_u (.*);
`default_nettype wire

// *** tb/tps_front_model.sv ***
// behavioural capacitive front end
`timescale 1ns/1ps
`default_nettype none
module tps_front_model (
   input  wire logic                 clk,
   output var  logic                 smp_valid,
   output var  tps_pkg::tps_sample_t smp,
   output var  logic [9:0]           slider_raw
);
   tps_pkg::tps_sample_t nxt;
   logic                 busy = 1'b0;
   initial begin
      smp_valid = 1'b0;
      smp = '0;
      slider_raw = 10'h000;
   end
   // idle cycles invert the lines so stale data never looks fresh
   always @(posedge clk) begin
      smp_valid <= busy;
      smp <= busy ? nxt : ~smp;
   end
   task automatic send(logic [4:0] el, logic t, logic nz, logic [9:0] c, int r);
      @(negedge clk);
      nxt = '{t, 1'b0, nz, el, c};
      busy = 1'b1;
      repeat (r) @(negedge clk);
      busy = 1'b0;
   endtask
   task automatic slide(logic [9:0] v);
      @(negedge clk);
      slider_raw = v;
   endtask
endmodule
`default_nettype wire
